// >>> rtl/iso_int_defs.vh
// constants and layout for the isochronous interrupt and bus init register bank
// Summary of operation
// - tx mask reads same at set/clear
// - tx mask bit gates matching tx event
// - tx event bits 7..0, upper reserved
// - tx summary feeds main event bit 6
// - rx completion with interrupt raises event
// - rx event set by edge or write-one
// - rx event cleared only by clear write
// - rx clear address reads event AND mask
// - rx event bits 3..0, upper zero
// - rx summary feeds main event bit 7
// - rx mask per context, reads at both
// - bandwidth field 13 bits, reset 1333h
// - bandwidth bits 31..13 read zero
// - bandwidth copied to CSR on resets except secondary
// - high channels 32 bits, reset ones
// - high channels copied to CSR on resets
`ifndef ISO_INT_DEFS_VH
`define ISO_INT_DEFS_VH
`define OFS_TX_EVT_SET     8'h90
`define OFS_TX_EVT_CLR     8'h94
`define OFS_TX_MASK_SET    8'h98
`define OFS_TX_MASK_CLR    8'h9c
`define OFS_RX_EVT_SET     8'ha0
`define OFS_RX_EVT_CLR     8'ha4
`define OFS_RX_MASK_SET    8'ha8
`define OFS_RX_MASK_CLR    8'hac
`define OFS_INIT_BW        8'hb0
`define OFS_INIT_CHAN_HI   8'hb4
`define OFS_IRQ_STATUS     8'hc0
`define OFS_IRQ_ENABLE     8'hc4
`define OFS_IRQ_CLEAR      8'hc8
`define TX_CTX_NUM         8
`define RX_CTX_NUM         4
`define BW_WIDTH           13
`define BW_RESET           13'h1333
`define CHAN_HI_RESET      32'hffff_ffff
`define MAIN_TX_BIT        6
`define MAIN_RX_BIT        7
`define IRQ_BIT_TX         0
`define IRQ_BIT_RX         1
`define IRQ_BIT_BUSRST     2
`endif

// >>> rtl/sync_edge.v
// two-flop synchroniser with rising-edge pulse for a group of pins
`timescale 1ns/100ps
module sync_edge #(
  parameter W = 4
) (
  input  wire         core_clk_in,  // clock
  input  wire         rst_b_in,     // async reset, active low
  input  wire [W-1:0] async_in,     // raw pins
  output wire [W-1:0] level_out,    // synchronised level
  output wire [W-1:0] rise_out      // one-cycle pulse on rising edge
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  reg [W-1:0] last_reg;
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
      last_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~last_reg;
endmodule // sync_edge

// >>> rtl/set_clear_bits.v
// bit vector with write-one-to-set, write-one-to-clear and hardware set
`timescale 1ns/100ps
module set_clear_bits #(
  parameter W = 8
) (
  input  wire         core_clk_in,  // clock
  input  wire         rst_b_in,     // async reset, active low
  input  wire [W-1:0] hw_set_in,    // hardware set pulses
  input  wire [W-1:0] sw_set_in,    // software write-one-to-set
  input  wire [W-1:0] sw_clr_in,    // software write-one-to-clear
  output reg  [W-1:0] bits_out      // stored bits
);
  // set wins over clear so an event landing on a clear is not lost
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bits_out <= {W{1'b0}};
    end else begin
      bits_out <= (bits_out & ~sw_clr_in) | sw_set_in | hw_set_in;
    end
  end
endmodule // set_clear_bits

// >>> rtl/iso_int_regs.v
// isochronous context interrupt event/mask registers and bus init values
`timescale 1ns/100ps
`include "iso_int_defs.vh"
module iso_int_regs (
  input  wire        core_clk_in,            // 100 MHz clock
  input  wire        rst_b_in,               // async reset, active low (system/software)
  input  wire [7:0]  addr_in,                // byte address
  input  wire [31:0] wdata_in,               // write data
  input  wire        wr_in,                  // write strobe
  input  wire        rd_in,                  // read strobe
  output reg  [31:0] rdata_out,              // read data, cycle after rd_in
  input  wire [7:0]  tx_ctx_int_in,          // tx context interrupt signals, async
  input  wire [3:0]  rx_ctx_int_in,          // rx context interrupt signals, async
  input  wire        bus_reset_in,           // 1394 bus reset, async level
  input  wire        global_reset_pin_in,    // global reset request, async level
  input  wire        perst_in,               // fundamental reset request, async level
  input  wire        secondary_reset_pin_in, // secondary reset request, async level
  output reg         tx_ctx_summary_int_out, // aggregate tx to main event bit 6
  output reg         rx_ctx_summary_int_out, // aggregate rx to main event bit 7
  output reg  [15:0] bw_avail_csr_out,       // bandwidth available CSR
  output reg  [31:0] chan_avail_hi_csr_out,  // channels available high CSR
  output reg         irq_out                 // level interrupt
);
  wire [7:0]  tx_rise;
  wire [3:0]  rx_rise;
  wire [31:0] tx_evt_set_data;
  wire [31:0] tx_mask_set_data;
  wire [31:0] tx_mask_clr_data;
  wire [31:0] rx_evt_set_data;
  wire [31:0] rx_evt_clr_data;
  wire [31:0] rx_mask_set_data;
  wire [31:0] rx_mask_clr_data;
  wire [3:0]  rst_rise;
  wire [7:0]  tx_evt;
  wire [7:0]  tx_mask;
  wire [3:0]  rx_evt;
  wire [3:0]  rx_mask;
  reg  [12:0] bw_reg;
  reg  [31:0] chan_hi_reg;
  reg  [2:0]  irq_stat_reg;
  reg  [2:0]  irq_en_reg;
  reg  [2:0]  irq_stat_next;
  reg  [31:0] rdata_next;
  reg         load_pend_reg;

  function [31:0] wsel;
    input [7:0] a;
    input [7:0] ofs;
    input       wr;
    input [31:0] d;
    begin
      wsel = (wr && (a == ofs)) ? d : 32'h0000_0000;
    end
  endfunction

  // per-address write data, zero unless this cycle writes that address
  assign tx_evt_set_data  = wsel(addr_in, `OFS_TX_EVT_SET, wr_in, wdata_in);
  assign tx_mask_set_data = wsel(addr_in, `OFS_TX_MASK_SET, wr_in, wdata_in);
  assign tx_mask_clr_data = wsel(addr_in, `OFS_TX_MASK_CLR, wr_in, wdata_in);
  assign rx_evt_set_data  = wsel(addr_in, `OFS_RX_EVT_SET, wr_in, wdata_in);
  assign rx_evt_clr_data  = wsel(addr_in, `OFS_RX_EVT_CLR, wr_in, wdata_in);
  assign rx_mask_set_data = wsel(addr_in, `OFS_RX_MASK_SET, wr_in, wdata_in);
  assign rx_mask_clr_data = wsel(addr_in, `OFS_RX_MASK_CLR, wr_in, wdata_in);

  sync_edge #(.W(8)) u_tx_sync (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .async_in    (tx_ctx_int_in),
    .level_out   (),
    .rise_out    (tx_rise)
  );
  sync_edge #(.W(4)) u_rx_sync (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .async_in    (rx_ctx_int_in),
    .level_out   (),
    .rise_out    (rx_rise)
  );
  sync_edge #(.W(4)) u_rst_sync (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .async_in    ({secondary_reset_pin_in, perst_in, global_reset_pin_in, bus_reset_in}),
    .level_out   (),
    .rise_out    (rst_rise)
  );

  // tx events set by context edges or the set address
  set_clear_bits #(.W(8)) u_tx_evt (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .hw_set_in   (tx_rise),
    .sw_set_in   (tx_evt_set_data[7:0]),
    .sw_clr_in   (8'h00),
    .bits_out    (tx_evt)
  );
  set_clear_bits #(.W(8)) u_tx_mask (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .hw_set_in   (8'h00),
    .sw_set_in   (tx_mask_set_data[7:0]),
    .sw_clr_in   (tx_mask_clr_data[7:0]),
    .bits_out    (tx_mask)
  );
  set_clear_bits #(.W(4)) u_rx_evt (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .hw_set_in   (rx_rise),
    .sw_set_in   (rx_evt_set_data[3:0]),
    .sw_clr_in   (rx_evt_clr_data[3:0]),
    .bits_out    (rx_evt)
  );
  set_clear_bits #(.W(4)) u_rx_mask (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .hw_set_in   (4'h0),
    .sw_set_in   (rx_mask_set_data[3:0]),
    .sw_clr_in   (rx_mask_clr_data[3:0]),
    .bits_out    (rx_mask)
  );

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bw_reg      <= `BW_RESET;
      chan_hi_reg <= `CHAN_HI_RESET;
    end else if (wr_in) begin
      if (addr_in == `OFS_INIT_BW)
        bw_reg <= wdata_in[12:0];
      if (addr_in == `OFS_INIT_CHAN_HI)
        chan_hi_reg <= wdata_in;
    end
  end

  // csr loads: pending after reset release, and on any reset request edge; bandwidth skips the secondary reset edge
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      load_pend_reg         <= 1'b1;
      bw_avail_csr_out      <= 16'h0000;
      chan_avail_hi_csr_out <= 32'h0000_0000;
    end else begin
      load_pend_reg <= 1'b0;
      if (load_pend_reg || (|rst_rise[2:0]))
        bw_avail_csr_out <= {3'b000, bw_reg};
      if (load_pend_reg || (|rst_rise))
        chan_avail_hi_csr_out <= chan_hi_reg;
    end
  end

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_ctx_summary_int_out <= 1'b0;
      rx_ctx_summary_int_out <= 1'b0;
    end else begin
      tx_ctx_summary_int_out <= |(tx_evt & tx_mask);
      rx_ctx_summary_int_out <= |(rx_evt & rx_mask);
    end
  end

  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_in && addr_in == `OFS_IRQ_CLEAR)
      irq_stat_next = irq_stat_next & ~wdata_in[2:0];
    irq_stat_next[`IRQ_BIT_TX]     = irq_stat_next[`IRQ_BIT_TX] | (|(tx_rise & tx_mask));
    irq_stat_next[`IRQ_BIT_RX]     = irq_stat_next[`IRQ_BIT_RX] | (|(rx_rise & rx_mask));
    irq_stat_next[`IRQ_BIT_BUSRST] = irq_stat_next[`IRQ_BIT_BUSRST] | rst_rise[0];
  end

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat_reg <= 3'b000;
      irq_en_reg   <= 3'b000;
      irq_out      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_in && addr_in == `OFS_IRQ_ENABLE)
        irq_en_reg <= wdata_in[2:0];
      irq_out <= |(irq_stat_next & irq_en_reg);
    end
  end

  always @* begin
    case (addr_in)
      `OFS_TX_EVT_SET:   rdata_next = {24'h00_0000, tx_evt};
      `OFS_TX_EVT_CLR:   rdata_next = {24'h00_0000, tx_evt & tx_mask};
      `OFS_TX_MASK_SET,
      `OFS_TX_MASK_CLR:  rdata_next = {24'h00_0000, tx_mask};
      `OFS_RX_EVT_SET:   rdata_next = {28'h000_0000, rx_evt};
      `OFS_RX_EVT_CLR:   rdata_next = {28'h000_0000, rx_evt & rx_mask};
      `OFS_RX_MASK_SET,
      `OFS_RX_MASK_CLR:  rdata_next = {28'h000_0000, rx_mask};
      `OFS_INIT_BW:      rdata_next = {19'h0_0000, bw_reg};
      `OFS_INIT_CHAN_HI: rdata_next = chan_hi_reg;
      `OFS_IRQ_STATUS:   rdata_next = {29'h0000_0000, irq_stat_reg};
      `OFS_IRQ_ENABLE:   rdata_next = {29'h0000_0000, irq_en_reg};
      default:           rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      rdata_out <= 32'h0000_0000;
    else if (rd_in)
      rdata_out <= rdata_next;
    else
      rdata_out <= 32'h0000_0000;
  end
endmodule // iso_int_regs

// >>> verification/iso_int_regs_properties.sv
// port checker for the iso interrupt register bank
`timescale 1ns/100ps
module iso_int_regs_properties (
  input wire        core_clk_in,            // clock
  input wire        rst_b_in,               // async reset, active low
  input wire        wr_in,                  // write strobe
  input wire        rd_in,                  // read strobe
  input wire [7:0]  addr_in,                // byte address
  input wire [31:0] rdata_out,              // read data
  input wire [31:0] chan_avail_hi_csr_out,  // channels csr
  input wire [15:0] bw_avail_csr_out,       // bandwidth csr
  input wire        tx_ctx_summary_int_out, // tx summary
  input wire        rx_ctx_summary_int_out, // rx summary
  input wire        bus_reset_in,           // bus reset pin
  input wire        global_reset_pin_in,    // global reset pin
  input wire        perst_in,               // fundamental reset pin
  input wire        secondary_reset_pin_in  // secondary reset pin
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  reg [7:0] ld_hist_reg;
  // preset so the load right after reset release is accepted
  always @(posedge core_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      ld_hist_reg <= 8'hff;
    else
      ld_hist_reg <= {ld_hist_reg[6:0],
                      bus_reset_in | global_reset_pin_in | perst_in | secondary_reset_pin_in};
  sequence s_rd(a); rd_in && addr_in == a; endsequence
  // each read is followed by an idle cycle, so paired reads sit two cycles apart
  property p_tx_alias;
    s_rd(8'h98) ##1 !wr_in ##1 s_rd(8'h9c) |=> rdata_out == $past(rdata_out, 2);
  endproperty
  a_tx_alias: assert property (p_tx_alias) else $error("tx mask aliases differ");
  property p_rx_alias;
    s_rd(8'ha8) ##1 !wr_in ##1 s_rd(8'hac) |=> rdata_out == $past(rdata_out, 2);
  endproperty
  a_rx_alias: assert property (p_rx_alias) else $error("rx mask aliases differ");
  property p_rx_and;
    s_rd(8'ha4) ##1 !wr_in ##1 s_rd(8'ha8) |=> ($past(rdata_out, 2) & ~rdata_out) == 32'h0;
  endproperty
  a_rx_and: assert property (p_rx_and) else $error("rx clear read not masked");
  property p_rx_sum; s_rd(8'ha4) |=> rx_ctx_summary_int_out == |rdata_out[3:0]; endproperty
  a_rx_sum: assert property (p_rx_sum) else $error("rx summary wrong");
  property p_tx_sum; s_rd(8'h94) |=> tx_ctx_summary_int_out == |rdata_out[7:0]; endproperty
  a_tx_sum: assert property (p_tx_sum) else $error("tx summary wrong");
  property p_bw_top; s_rd(8'hb0) |=> rdata_out[31:13] == 0; endproperty
  a_bw_top: assert property (p_bw_top) else $error("bandwidth upper bits set");
  property p_rx_top; s_rd(8'ha0) |=> rdata_out[31:4] == 0; endproperty
  a_rx_top: assert property (p_rx_top) else $error("rx event upper bits set");
  property p_bw_load; $changed(bw_avail_csr_out) |-> |ld_hist_reg; endproperty
  a_bw_load: assert property (p_bw_load) else $error("bandwidth csr moved unasked");
  property p_ch_load; $changed(chan_avail_hi_csr_out) |-> |ld_hist_reg; endproperty
  a_ch_load: assert property (p_ch_load) else $error("channels csr moved unasked");
  c_rx_and: cover property (s_rd(8'ha4) ##1 !wr_in ##1 s_rd(8'ha8));
  c_rx_sum: cover property ($rose(rx_ctx_summary_int_out));
  c_ch_load: cover property ($changed(chan_avail_hi_csr_out));
endmodule // iso_int_regs_properties
bind iso_int_regs iso_int_regs_properties i_props (
  .core_clk_in            (core_clk_in),
  .rst_b_in               (rst_b_in),
  .wr_in                  (wr_in),
  .rd_in                  (rd_in),
  .addr_in                (addr_in),
  .rdata_out              (rdata_out),
  .chan_avail_hi_csr_out  (chan_avail_hi_csr_out),
  .bw_avail_csr_out       (bw_avail_csr_out),
  .tx_ctx_summary_int_out (tx_ctx_summary_int_out),
  .rx_ctx_summary_int_out (rx_ctx_summary_int_out),
  .bus_reset_in           (bus_reset_in),
  .global_reset_pin_in    (global_reset_pin_in),
  .perst_in               (perst_in),
  .secondary_reset_pin_in (secondary_reset_pin_in)
);

// >>> verification/iso_int_regs_bench.sv
// self-checking bench for the iso interrupt register bank
`timescale 1ns/100ps
module iso_int_regs_bench;
  reg         core_clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  reg  [7:0]  addr_in = 8'h00, tx_pin = 8'h00, txm = 8'h00, txe = 8'hff;
  reg  [31:0] wdata_in = 32'h0000_0000, lfsr = 32'h0000_f155, r;
  reg  [3:0]  rx_pin = 4'h0, rst_pins = 4'h0, rxm = 4'h0, rxe = 4'h0;
  reg  [12:0] bwx;
  wire [31:0] rdata_out, ch_csr;
  wire [15:0] bw_csr;
  wire        tx_sum, rx_sum, irq;
  integer     fails = 0, num_checks = 0, cyc = 0, i;
  iso_int_regs i_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .tx_ctx_int_in(tx_pin), .rx_ctx_int_in(rx_pin), .bus_reset_in(rst_pins[0]),
    .global_reset_pin_in(rst_pins[1]), .perst_in(rst_pins[2]),
    .secondary_reset_pin_in(rst_pins[3]), .tx_ctx_summary_int_out(tx_sum),
    .rx_ctx_summary_int_out(rx_sum), .bw_avail_csr_out(bw_csr),
    .chan_avail_hi_csr_out(ch_csr), .irq_out(irq));
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000)
      end_of_test;
  end
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // called at a rising edge; strobes stay up so that calls can follow each other with no gap
  task op(input w, input [7:0] a, input [31:0] d);
    begin
      wr_in <= w;
      rd_in <= !w;
      addr_in <= a;
      wdata_in <= d;
      @(posedge core_clk_in);
    end
  endtask
  task idle(input integer n);
    begin
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      repeat (n) @(posedge core_clk_in);
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rdc(input string nm, input [7:0] a, input [31:0] e);
    begin
      op(1'b0, a, 32'h0000_0000);
      // read data stand for the one cycle after the strobe; taken at the edge that ends it
      idle(1);
      chk(nm, e, rdata_out);
    end
  endtask
  task end_of_test;
    begin
      if (cyc >= 20000)
        fails = fails + 1;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    idle(1);
    rdc("bw", 8'hb0, 32'h0000_1333);
    rdc("chan", 8'hb4, 32'hffff_ffff);
    chk("bw_csr", 32'h0000_1333, {16'h0000, bw_csr});
    chk("ch_csr", 32'hffff_ffff, ch_csr);
    rdc("unmapped", 8'h00, 32'h0000_0000);
    op(1, 8'h9c, 32'hffff_ffff);
    op(1, 8'hac, 32'hffff_ffff);
    op(1, 8'ha4, 32'hffff_ffff);
    op(1, 8'h90, 32'hffff_ffff);
    for (i = 0; i < 40; i = i + 1) begin
      lfsr = nxt(lfsr);
      r = lfsr;
      rxe = rxe | (r[3:0] & ~rx_pin);
      rx_pin <= r[3:0];
      tx_pin <= r[11:4];
      idle(5);
      op(1, 8'h98, r);
      op(1, 8'h9c, r >> 16);
      op(1, 8'ha8, r >> 4);
      op(1, 8'hac, r >> 12);
      op(1, 8'ha0, r >> 20);
      op(1, 8'ha4, r >> 24);
      txm = (txm | r[7:0]) & ~r[23:16];
      rxm = (rxm | r[7:4]) & ~r[15:12];
      rxe = (rxe | r[23:20]) & ~r[27:24];
      rdc("tx_mask_s", 8'h98, {24'h0, txm});
      rdc("tx_mask_c", 8'h9c, {24'h0, txm});
      rdc("tx_evt_and", 8'h94, {24'h0, txe & txm});
      rdc("tx_evt", 8'h90, {24'h0, txe});
      rdc("rx_evt", 8'ha0, {28'h0, rxe});
      rdc("rx_evt_and", 8'ha4, {28'h0, rxe & rxm});
      rdc("rx_mask_s", 8'ha8, {28'h0, rxm});
      rdc("rx_mask_c", 8'hac, {28'h0, rxm});
      chk("rx_sum", {31'h0, |(rxe & rxm)}, {31'h0, rx_sum});
      chk("tx_sum", {31'h0, |(txe & txm)}, {31'h0, tx_sum});
    end
    op(1, 8'hc8, 32'h0000_0007);
    op(1, 8'hc4, 32'h0000_0004);
    for (i = 0; i < 4; i = i + 1) begin
      lfsr = nxt(lfsr);
      op(1, 8'hb0, lfsr);
      op(1, 8'hb4, ~lfsr);
      rst_pins <= 4'h1 << i;
      idle(6);
      rst_pins <= 4'h0;
      if (i != 3)
        bwx = lfsr[12:0];
      chk("bw_csr", {19'h0, bwx}, {16'h0000, bw_csr});
      chk("ch_csr", ~lfsr, ch_csr);
      rdc("bw", 8'hb0, {19'h0, lfsr[12:0]});
      rdc("chan", 8'hb4, ~lfsr);
    end
    idle(2);
    chk("irq_on", 32'h1, {31'h0, irq});
    op(1, 8'hc4, 32'h0000_0000);
    idle(3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc("status", 8'hc0, 32'h0000_0004);
    op(1, 8'hc8, 32'h0000_0004);
    op(1, 8'hc4, 32'h0000_0004);
    idle(3);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    // pins low first: a pin held high across reset would read as a fresh edge
    tx_pin <= 8'h00;
    rx_pin <= 4'h0;
    rst_b_in <= 1'b0;
    idle(2);
    chk("irq_rst", 32'h0, {31'h0, irq});
    rst_b_in <= 1'b1;
    idle(1);
    rdc("bw_rst", 8'hb0, 32'h0000_1333);
    rdc("chan_rst", 8'hb4, 32'hffff_ffff);
    chk("bw_csr_rst", 32'h0000_1333, {16'h0000, bw_csr});
    chk("ch_csr_rst", 32'hffff_ffff, ch_csr);
    chk("rx_sum_rst", 32'h0, {31'h0, rx_sum});
    end_of_test;
  end
endmodule // iso_int_regs_bench
